// >>> hdl/ssm_pkg.sv
// Behaviour
// R1: Limited-speed request with speed below limit starts monitoring and sets indication.
// R2: Trip limit reached during monitoring clears the limited-speed indication.
// R3: Immediate mode: after response time, emergency stop and torque off, motor coasts.
// R4: Immediate mode with encoder: indication returns when speed falls below limit.
// R5: Zero-speed threshold reached: motor stopped, done flag set, acknowledge allowed.
// R6: Ramp mode: after response time, emergency stop and emergency ramp command.
// R7: Ramp mode opens torque off only at zero speed, then sets done flag.
// R8: Request withdrawn with manual or controller acknowledge keeps monitoring on.
// R9: One acknowledge ends monitoring, acknowledges emergency stop, clears indications.
// R10: Scaled mode: ramp monitoring limit hit while decelerating removes torque.
// R11: Time monitoring: monitoring starts at delay expiry, trip then stops.
// R12: Fixed, maximum-speed and scaled limits together: lowest limit is enforced.
// R13: Scale base limit and trip by percentage, hold until new value.
// R14: Scaled limits never exceed the unscaled fourth limit set.
// R15: Positive limits scale only with positive bit, negative only with negative bit.
// R16: Scaling value is unsigned high and low bytes in hundredths of percent.
// R17: One scaling value applies alike to positive and negative limits.
// R18: Controller should send unsigned scaling below one hundred percent.
// R19: Controller delivers each scaling request inside a safety message.
// R20: New scaling before previous limits reached restarts the time delay.
// R21: After new lower scaling, existing limits hold until new limit reached.
// R22: Response time from trip to emergency stop is a cycle count.
package ssm_pkg;
   // ***************************************************
   // Register offsets
   // ***************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BASE = 8'h04;
   localparam logic [7:0] ADDR_FIXED = 8'h08;
   localparam logic [7:0] ADDR_MAXSPD = 8'h0C;
   localparam logic [7:0] ADDR_ZERO = 8'h10;
   localparam logic [7:0] ADDR_DELAY = 8'h14;
   localparam logic [7:0] ADDR_RESP = 8'h18;
   localparam logic [7:0] ADDR_RAMP = 8'h1C;
   localparam logic [7:0] ADDR_ACK = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [7:0] ADDR_PCT = 8'h28;

   // ***************************************************
   // Control fields
   // ***************************************************
   localparam int CTRL_W = 7;
   localparam int CTRL_RAMP_MODE = 0;
   localparam int CTRL_AUTO_ACK = 1;
   localparam int CTRL_SCALED = 2;
   localparam int CTRL_TIME_MON = 3;
   localparam int CTRL_ENCODER = 4;
   localparam int CTRL_MAXSPD = 5;
   localparam int CTRL_FIXED = 6;
   localparam int HI_POS = 16;

   // ***************************************************
   // Reset values and scaling
   // ***************************************************
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
   localparam logic [31:0] BASE_RST = 32'h0C00_0800;
   localparam logic [31:0] FIXED_RST = 32'hFFFF_FFFF;
   localparam logic [31:0] MAXSPD_RST = 32'h0000_FFFF;
   localparam logic [31:0] ZERO_RST = 32'h0010_0010;
   localparam logic [31:0] DELAY_RST = 32'h0000_1000;
   localparam logic [15:0] RESP_RST = 16'h000A;
   localparam logic [31:0] RAMP_RST = 32'h0000_FFFF;
   localparam logic [15:0] SCALE_FULL = 16'h2710;

   // ***************************************************
   // Stop sequence states
   // ***************************************************
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_MON = 6'h02,
      ST_RESP = 6'h04,
      ST_COAST = 6'h08,
      ST_RAMP = 6'h10,
      ST_DONE = 6'h20
   } ssm_state_t;
endpackage : ssm_pkg

// >>> hdl/ssm_scale.sv
`timescale 1ns/1ps
// ***************************************************
// Percentage scaler for one limit
// ***************************************************
module ssm_scale #(
   parameter int W = 16
) (
   input wire logic [W-1:0] base_i,
   input wire logic [15:0] pct_i,
   output logic [W-1:0] scaled_o
);
   logic [W+15:0] prod;
   logic [W+15:0] quot;

   // Hundredths of a percent, clamped at the base value
   always_comb begin
      prod = base_i * pct_i; // R16
      quot = prod / (W+16)'(ssm_pkg::SCALE_FULL);
      if (pct_i >= ssm_pkg::SCALE_FULL) begin
         scaled_o = base_i; // R14
      end else begin
         scaled_o = quot[W-1:0]; // R13
      end
   end
endmodule : ssm_scale

// >>> hdl/ssm_top.sv
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ssm_top #(
   parameter int SPD_W = 16
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic signed [SPD_W-1:0] motor_speed_i,
   input wire logic lsf_req_i,
   input wire logic ack_i,
   input wire logic decel_i,
   input wire logic scale_valid_i,
   input wire logic scale_pos_i,
   input wire logic scale_neg_i,
   input wire logic [7:0] scale_hi_i,
   input wire logic [7:0] scale_lo_i,
   output logic limited_speed_indication_o,
   output logic emergency_stop_active_o,
   output logic torque_off_o,
   output logic emergency_ramp_o,
   output logic emergency_stop_done_flag_o,
   output logic scaled_limit_active_flag_o,
   output logic ack_allowed_o
);
   // ***************************************************
   // Declarations
   // ***************************************************
   ssm_pkg::ssm_state_t state_ff, nxt_state;
   logic [ssm_pkg::CTRL_W-1:0] ctrl_ff;
   logic [31:0] base_ff, fixed_ff, maxspd_ff, zero_ff, delay_ff, ramp_ff;
   logic [15:0] resp_ff, resp_cnt_ff;
   logic [31:0] delay_cnt_ff;
   logic delay_run_ff, delay_exp, delay_start;
   logic sw_ack_ff, ack_any, sto_only_ff;
   logic wr_pend_ff, rd_pend_ff, ap;
   logic [7:0] addr_ff;
   logic [15:0] pos_pct_ff, neg_pct_ff, pend_pos_ff, pend_neg_ff;
   logic pend_ff, pend_hit;
   logic [15:0] pct_arr [6];
   logic [SPD_W-1:0] base_arr [6];
   logic [SPD_W-1:0] scl_arr [6];
   logic neg_dir;
   logic [SPD_W-1:0] mag, lim_eff, trip_eff, zero_thr;
   logic ind_ff, estop_ff, torque_ff, ramp_cmd_ff, done_ff, scl_act_ff, ack_ok_ff;
   logic [31:0] hrdata_ff;
   logic hready_ff;

   // Lower of two limits
   function automatic logic [SPD_W-1:0] min_spd(input logic [SPD_W-1:0] a, input logic [SPD_W-1:0] b);
      min_spd = (a < b) ? a : b;
   endfunction : min_spd

   // ***************************************************
   // Bus slave
   // ***************************************************
   assign ap = hsel_i & htrans_i[1] & hready_i;
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_ff;
   assign hreadyout_o = hready_ff;

   // Address phase capture; reads take one wait state
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 8'h00;
         hready_ff <= 1'b1;
      end else begin
         wr_pend_ff <= ap & hwrite_i;
         rd_pend_ff <= ap & ~hwrite_i;
         hready_ff <= ~(ap & ~hwrite_i);
         if (ap) begin
            addr_ff <= haddr_i[7:0];
         end
      end
   end

   // Read data mux, unmapped reads return zero
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rd_pend_ff) begin
         unique case (addr_ff)
            ssm_pkg::ADDR_CTRL: hrdata_ff <= 32'(ctrl_ff);
            ssm_pkg::ADDR_BASE: hrdata_ff <= base_ff;
            ssm_pkg::ADDR_FIXED: hrdata_ff <= fixed_ff;
            ssm_pkg::ADDR_MAXSPD: hrdata_ff <= maxspd_ff;
            ssm_pkg::ADDR_ZERO: hrdata_ff <= zero_ff;
            ssm_pkg::ADDR_DELAY: hrdata_ff <= delay_ff;
            ssm_pkg::ADDR_RESP: hrdata_ff <= 32'(resp_ff);
            ssm_pkg::ADDR_RAMP: hrdata_ff <= ramp_ff;
            ssm_pkg::ADDR_STATUS: hrdata_ff <= 32'({pend_ff, scl_act_ff, done_ff, ramp_cmd_ff, torque_ff,
                                                    estop_ff, ind_ff, state_ff});
            ssm_pkg::ADDR_PCT: hrdata_ff <= {neg_pct_ff, pos_pct_ff};
            default: hrdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // Configuration registers, written in the data phase
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_ff <= ssm_pkg::CTRL_RST;
         base_ff <= ssm_pkg::BASE_RST;
         fixed_ff <= ssm_pkg::FIXED_RST;
         maxspd_ff <= ssm_pkg::MAXSPD_RST;
         zero_ff <= ssm_pkg::ZERO_RST;
         delay_ff <= ssm_pkg::DELAY_RST;
         resp_ff <= ssm_pkg::RESP_RST;
         ramp_ff <= ssm_pkg::RAMP_RST;
      end else if (wr_pend_ff) begin
         unique case (addr_ff)
            ssm_pkg::ADDR_CTRL: ctrl_ff <= hwdata_i[ssm_pkg::CTRL_W-1:0];
            ssm_pkg::ADDR_BASE: base_ff <= hwdata_i;
            ssm_pkg::ADDR_FIXED: fixed_ff <= hwdata_i;
            ssm_pkg::ADDR_MAXSPD: maxspd_ff <= hwdata_i;
            ssm_pkg::ADDR_ZERO: zero_ff <= hwdata_i;
            ssm_pkg::ADDR_DELAY: delay_ff <= hwdata_i;
            ssm_pkg::ADDR_RESP: resp_ff <= hwdata_i[15:0];
            ssm_pkg::ADDR_RAMP: ramp_ff <= hwdata_i;
            default: ;
         endcase
      end
   end

   // Software acknowledge pulse
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sw_ack_ff <= 1'b0;
      end else begin
         sw_ack_ff <= wr_pend_ff & (addr_ff == ssm_pkg::ADDR_ACK) & hwdata_i[0];
      end
   end

   assign ack_any = ack_i | sw_ack_ff;

   // ***************************************************
   // Speed magnitude and limits
   // ***************************************************
   assign neg_dir = motor_speed_i[SPD_W-1];
   assign mag = neg_dir ? SPD_W'(-motor_speed_i) : SPD_W'(motor_speed_i);
   assign zero_thr = ctrl_ff[ssm_pkg::CTRL_ENCODER] ? zero_ff[SPD_W-1:0] : zero_ff[ssm_pkg::HI_POS +: SPD_W];

   // Scaler inputs: active pos lim/trip, active neg lim/trip, pending pos/neg lim
   always_comb begin
      pct_arr[0] = pos_pct_ff;
      pct_arr[1] = pos_pct_ff;
      pct_arr[2] = neg_pct_ff; // R17
      pct_arr[3] = neg_pct_ff;
      pct_arr[4] = pend_pos_ff;
      pct_arr[5] = pend_neg_ff;
      for (int k = 0; k < 6; k++) begin
         base_arr[k] = (k % 2 == 1 && k < 4) ? base_ff[ssm_pkg::HI_POS +: SPD_W] : base_ff[SPD_W-1:0];
      end
   end

   generate
      for (genvar g = 0; g < 6; g++) begin : g_scale
         ssm_scale #(.W(SPD_W)) u_scale (
            .base_i(base_arr[g]),
            .pct_i(pct_arr[g]),
            .scaled_o(scl_arr[g])
         );
      end
   endgenerate

   // Lowest of all enabled limits is enforced
   always_comb begin
      lim_eff = base_ff[SPD_W-1:0];
      trip_eff = base_ff[ssm_pkg::HI_POS +: SPD_W];
      if (ctrl_ff[ssm_pkg::CTRL_SCALED]) begin
         lim_eff = neg_dir ? scl_arr[2] : scl_arr[0];
         trip_eff = neg_dir ? scl_arr[3] : scl_arr[1];
      end
      if (ctrl_ff[ssm_pkg::CTRL_FIXED]) begin
         lim_eff = min_spd(lim_eff, fixed_ff[SPD_W-1:0]); // R12
         trip_eff = min_spd(trip_eff, fixed_ff[ssm_pkg::HI_POS +: SPD_W]);
      end
      if (ctrl_ff[ssm_pkg::CTRL_MAXSPD]) begin
         lim_eff = min_spd(lim_eff, maxspd_ff[SPD_W-1:0]); // R12
         trip_eff = min_spd(trip_eff, maxspd_ff[SPD_W-1:0]);
      end
   end

   // ***************************************************
   // Scaling message handling
   // ***************************************************
   assign pend_hit = pend_ff & ((mag <= (neg_dir ? scl_arr[5] : scl_arr[4])) | delay_exp);

   // New message wins over applying the previous one
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pos_pct_ff <= ssm_pkg::SCALE_FULL;
         neg_pct_ff <= ssm_pkg::SCALE_FULL;
         pend_pos_ff <= ssm_pkg::SCALE_FULL;
         pend_neg_ff <= ssm_pkg::SCALE_FULL;
         pend_ff <= 1'b0;
      end else if (scale_valid_i) begin
         pend_pos_ff <= scale_pos_i ? {scale_hi_i, scale_lo_i} : pos_pct_ff; // R15 R16
         pend_neg_ff <= scale_neg_i ? {scale_hi_i, scale_lo_i} : neg_pct_ff; // R15 R17
         pend_ff <= 1'b1;
      end else if (pend_hit) begin
         pos_pct_ff <= pend_pos_ff; // R21
         neg_pct_ff <= pend_neg_ff; // R13
         pend_ff <= 1'b0;
      end
   end

   // ***************************************************
   // Time monitoring delay
   // ***************************************************
   assign delay_exp = delay_run_ff & (delay_cnt_ff == 32'h0000_0000);
   assign delay_start = ctrl_ff[ssm_pkg::CTRL_TIME_MON] & ((scale_valid_i & ctrl_ff[ssm_pkg::CTRL_SCALED]) |
                        (state_ff == ssm_pkg::ST_IDLE & lsf_req_i & ~delay_run_ff & mag >= lim_eff));

   // Delay restarts from the beginning on every start
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         delay_run_ff <= 1'b0;
         delay_cnt_ff <= 32'h0000_0000;
      end else if (delay_start) begin
         delay_run_ff <= 1'b1; // R20
         delay_cnt_ff <= delay_ff;
      end else if (delay_exp) begin
         delay_run_ff <= 1'b0;
      end else if (delay_run_ff) begin
         delay_cnt_ff <= delay_cnt_ff - 32'h0000_0001;
      end
   end

   // ***************************************************
   // Stop sequence
   // ***************************************************
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ssm_pkg::ST_IDLE: begin
            if (lsf_req_i && (mag < lim_eff || delay_exp)) begin
               nxt_state = ssm_pkg::ST_MON; // R1 R11
            end
         end
         ssm_pkg::ST_MON: begin
            if (ack_any) begin
               nxt_state = ssm_pkg::ST_IDLE; // R9
            end else if (!lsf_req_i && ctrl_ff[ssm_pkg::CTRL_AUTO_ACK]) begin
               nxt_state = ssm_pkg::ST_IDLE; // R8
            end else if (mag >= trip_eff) begin
               nxt_state = ssm_pkg::ST_RESP; // R2 R11
            end else if (ctrl_ff[ssm_pkg::CTRL_SCALED] && decel_i && mag > ramp_ff[SPD_W-1:0]) begin
               nxt_state = ssm_pkg::ST_COAST; // R10
            end
         end
         ssm_pkg::ST_RESP: begin
            if (resp_cnt_ff <= 16'h0001) begin
               nxt_state = ctrl_ff[ssm_pkg::CTRL_RAMP_MODE] ? ssm_pkg::ST_RAMP : ssm_pkg::ST_COAST; // R3 R6
            end
         end
         ssm_pkg::ST_COAST, ssm_pkg::ST_RAMP: begin
            if (mag <= zero_thr) begin
               nxt_state = ssm_pkg::ST_DONE; // R5 R7
            end
         end
         ssm_pkg::ST_DONE: begin
            if (ack_any) begin
               nxt_state = ssm_pkg::ST_IDLE; // R9
            end
         end
         default: nxt_state = ssm_pkg::ST_IDLE;
      endcase
   end

   // State register and response time counter
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= ssm_pkg::ST_IDLE;
         resp_cnt_ff <= 16'h0000;
         sto_only_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff != ssm_pkg::ST_RESP) begin
            resp_cnt_ff <= resp_ff; // R22
         end else begin
            resp_cnt_ff <= resp_cnt_ff - 16'h0001;
         end
         if (state_ff == ssm_pkg::ST_MON && nxt_state == ssm_pkg::ST_COAST) begin
            sto_only_ff <= 1'b1;
         end else if (nxt_state == ssm_pkg::ST_IDLE) begin
            sto_only_ff <= 1'b0;
         end
      end
   end

   // Indications follow the next state so they line up with it
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ind_ff <= 1'b0;
         estop_ff <= 1'b0;
         torque_ff <= 1'b0;
         ramp_cmd_ff <= 1'b0;
         done_ff <= 1'b0;
         scl_act_ff <= 1'b0;
         ack_ok_ff <= 1'b0;
      end else begin
         unique case (nxt_state)
            ssm_pkg::ST_MON: ind_ff <= 1'b1; // R1
            ssm_pkg::ST_COAST, ssm_pkg::ST_RAMP, ssm_pkg::ST_DONE: ind_ff <= mag < lim_eff; // R4
            default: ind_ff <= 1'b0; // R2 R9
         endcase
         estop_ff <= (nxt_state == ssm_pkg::ST_RAMP || nxt_state == ssm_pkg::ST_DONE ||
                      nxt_state == ssm_pkg::ST_COAST) &&
                     !(sto_only_ff || (state_ff == ssm_pkg::ST_MON && nxt_state == ssm_pkg::ST_COAST)); // R3 R6
         torque_ff <= nxt_state == ssm_pkg::ST_COAST || nxt_state == ssm_pkg::ST_DONE; // R3 R7 R10
         ramp_cmd_ff <= nxt_state == ssm_pkg::ST_RAMP; // R6
         done_ff <= nxt_state == ssm_pkg::ST_DONE; // R5 R7
         scl_act_ff <= nxt_state == ssm_pkg::ST_MON && ctrl_ff[ssm_pkg::CTRL_SCALED] && !pend_ff && mag <= lim_eff;
         ack_ok_ff <= nxt_state == ssm_pkg::ST_MON || nxt_state == ssm_pkg::ST_DONE; // R5
      end
   end

   assign limited_speed_indication_o = ind_ff;
   assign emergency_stop_active_o = estop_ff;
   assign torque_off_o = torque_ff;
   assign emergency_ramp_o = ramp_cmd_ff;
   assign emergency_stop_done_flag_o = done_ff;
   assign scaled_limit_active_flag_o = scl_act_ff;
   assign ack_allowed_o = ack_ok_ff;
endmodule : ssm_top

// >>> tb/ssm_drive_model.sv
`timescale 1ns/1ps
// ***************************************************
// Drive and encoder model on the far side
// ***************************************************
module ssm_drive_model (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic signed [15:0] target_i,
   input wire logic torque_off_i,
   input wire logic ramp_i,
   output logic signed [15:0] speed_o,
   output logic decel_o
);
   logic signed [15:0] goal;
   // Coasting and the emergency ramp both head for standstill
   assign goal = (torque_off_i || ramp_i) ? 16'sh0000 : target_i;
   assign decel_o = (goal < speed_o);
   // Speed moves one step a cycle toward the goal
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         speed_o <= 16'sh0000;
      end else if (goal - speed_o > 16'sh0040) begin
         speed_o <= speed_o + 16'sh0040;
      end else if (speed_o - goal > 16'sh0040) begin
         speed_o <= speed_o - 16'sh0040;
      end else begin
         speed_o <= goal;
      end
   end
endmodule : ssm_drive_model

// >>> tb/ssm_top_asserts.sv
`timescale 1ns/1ps
module ssm_top_asserts (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic ack_i,
   input wire logic limited_speed_indication_o,
   input wire logic emergency_stop_active_o,
   input wire logic torque_off_o,
   input wire logic emergency_ramp_o,
   input wire logic emergency_stop_done_flag_o,
   input wire logic ack_allowed_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   // ***************************************************
   // Sequences
   // ***************************************************
   sequence rd_taken;
      hsel_i && htrans_i[1] && hready_i && !hwrite_i;
   endsequence
   sequence rd_answer;
      !hreadyout_o ##1 hreadyout_o;
   endsequence
   sequence all_clear;
      !limited_speed_indication_o && !emergency_stop_active_o && !torque_off_o
      && !emergency_ramp_o && !emergency_stop_done_flag_o;
   endsequence
   // ***************************************************
   // Assertions
   // ***************************************************
   a_read_wait: assert property (rd_taken |=> rd_answer) else $error("read answer timing wrong");
   a_resp_okay: assert property (hresp_o == 1'b0) else $error("response not okay");
   a_ack_clears: assert property (ack_i && ack_allowed_o |=> all_clear)
      else $error("acknowledge did not clear outputs");
   a_ack_refused: assert property (ack_i && !ack_allowed_o && emergency_stop_active_o
      |=> emergency_stop_active_o) else $error("refused acknowledge ended stop");
   a_stop_after_trip: assert property ($rose(emergency_stop_active_o)
      |-> !$past(limited_speed_indication_o)) else $error("stop without trip");
   a_stop_action: assert property ($rose(emergency_stop_active_o) |-> torque_off_o != emergency_ramp_o)
      else $error("stop took no single action");
   a_ramp_no_torque: assert property (emergency_ramp_o |-> emergency_stop_active_o && !torque_off_o)
      else $error("torque off during ramp");
   a_done_torque: assert property (emergency_stop_done_flag_o |-> torque_off_o && ack_allowed_o
      && !emergency_ramp_o) else $error("done without torque off");
   a_no_early_ack: assert property (emergency_stop_active_o && !emergency_stop_done_flag_o
      |-> !ack_allowed_o) else $error("acknowledge allowed too early");
   a_done_holds: assert property (emergency_stop_done_flag_o && !ack_i |=> emergency_stop_done_flag_o)
      else $error("done dropped without acknowledge");
endmodule : ssm_top_asserts

bind ssm_top ssm_top_asserts u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .ack_i(ack_i), .limited_speed_indication_o(limited_speed_indication_o),
   .emergency_stop_active_o(emergency_stop_active_o), .torque_off_o(torque_off_o),
   .emergency_ramp_o(emergency_ramp_o), .emergency_stop_done_flag_o(emergency_stop_done_flag_o),
   .ack_allowed_o(ack_allowed_o));

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, nrst, hwr, hrdy, hresp, req, ack, dec, sv, sp, sn;
   logic [1:0] htr;
   logic [7:0] shi, slo;
   logic [31:0] haddr, hwd, hrd, exp_q[$];
   logic signed [15:0] speed, target;
   logic ind, est, trq, rmp, dn, scl, aka, rd_dp = 1'b0, probe = 1'b0;
   logic [6:0] outs;
   logic [15:0] lfsr = 16'h000D;
   int n_mismatch = 0, checked = 0;
   assign outs = {scl, ind, est, trq, rmp, dn, aka};
   // Clock of 10 ns
   initial begin
      forever #5 clk = ~clk;
   end
   ssm_top uut (.clk_sys_i(clk), .nrst_i(nrst), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htr),
      .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy), .hrdata_o(hrd),
      .hreadyout_o(hrdy), .hresp_o(hresp), .motor_speed_i(speed), .lsf_req_i(req), .ack_i(ack),
      .decel_i(dec), .scale_valid_i(sv), .scale_pos_i(sp), .scale_neg_i(sn), .scale_hi_i(shi),
      .scale_lo_i(slo), .limited_speed_indication_o(ind), .emergency_stop_active_o(est),
      .torque_off_o(trq), .emergency_ramp_o(rmp), .emergency_stop_done_flag_o(dn),
      .scaled_limit_active_flag_o(scl), .ack_allowed_o(aka));
   ssm_drive_model u_drv (.clk_i(clk), .nrst_i(nrst), .target_i(target), .torque_off_i(trq),
      .ramp_i(rmp), .speed_o(speed), .decel_o(dec));
   // ***************************************************
   // Tasks
   // ***************************************************
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction : rnd
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   // One single AHB transfer, waits on the slave's ready
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hwr <= wr;
      haddr <= {24'h000000, a};
      htr <= 2'h2;
      do @(posedge clk); while (hrdy !== 1'b1);
      htr <= 2'h0;
      hwd <= d;
      rd_dp <= !wr;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd_dp <= 1'b0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h00000000);
   endtask : rd
   task automatic expect_out(input logic [6:0] e);
      exp_q.push_back({25'h0000000, e});
      @(posedge clk);
      probe <= 1'b1;
      @(posedge clk);
      probe <= 1'b0;
   endtask : expect_out
   task automatic wait_on(input int b, input int lim);
      for (int i = 0; i < lim && outs[b] !== 1'b1; i++) @(posedge clk);
   endtask : wait_on
   task automatic pulse_ack();
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
   endtask : pulse_ack
   task automatic scale(input logic p, input logic n, input logic [15:0] v);
      @(posedge clk);
      {sp, sn, shi, slo} <= {p, n, v};
      sv <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
   endtask : scale
   // Stop runs to standstill, then one acknowledge ends it all
   task automatic finish_stop();
      wait_on(1, 600);
      expect_out(7'b0111011);
      req <= 1'b0;
      target <= 16'sh0000;
      repeat (5) @(posedge clk);
      expect_out(7'b0111011);
      pulse_ack();
      expect_out(7'b0000000);
   endtask : finish_stop
   task automatic trip(input logic rampm);
      bus(1'b1, ssm_pkg::ADDR_CTRL, {27'h0000000, 1'b1, 3'h0, rampm});
      target <= 16'sh0400;
      req <= 1'b1;
      wait_on(5, 200);
      expect_out(7'b0100001);
      target <= 16'sh0D00;
      wait_on(4, 400);
      expect_out(rampm ? 7'b0010100 : 7'b0011000);
      pulse_ack();
      finish_stop();
   endtask : trip
   // ***************************************************
   // Result monitor
   // ***************************************************
   always @(posedge clk) begin
      if (rd_dp && hrdy) check("hrdata", hrd, exp_q.pop_front());
      if (probe) check("outputs", {25'h0000000, outs}, exp_q.pop_front());
   end
   initial begin
      repeat (10000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end
   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      logic [15:0] v, pos, neg;
      {nrst, hwr, htr, haddr, hwd, req, ack, sv, sp, sn, shi, slo} = '0;
      target = 16'sh0000;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(ssm_pkg::ADDR_BASE, ssm_pkg::BASE_RST);
      rd(8'h3C, 32'h00000000);
      bus(1'b1, ssm_pkg::ADDR_RESP, 32'h00000003);
      rd(ssm_pkg::ADDR_RESP, 32'h00000003);
      trip(1'b0);
      trip(1'b1);
      // Time monitoring forces monitoring with speed above trip
      bus(1'b1, ssm_pkg::ADDR_DELAY, 32'h00000005);
      bus(1'b1, ssm_pkg::ADDR_CTRL, 32'h00000018);
      target <= 16'sh0D00;
      repeat (60) @(posedge clk);
      req <= 1'b1;
      wait_on(4, 100);
      expect_out(7'b0011000);
      finish_stop();
      bus(1'b1, ssm_pkg::ADDR_CTRL, 32'h00000014);
      pos = ssm_pkg::SCALE_FULL;
      neg = ssm_pkg::SCALE_FULL;
      for (int i = 0; i < 4; i++) begin
         v = rnd() % ssm_pkg::SCALE_FULL;
         scale(i[0], i[1], v);
         pos = i[0] ? v : pos;
         neg = i[1] ? v : neg;
         repeat (3) @(posedge clk);
         rd(ssm_pkg::ADDR_PCT, {neg, pos});
      end
      scale(1'b1, 1'b1, 16'h1388);
      target <= 16'sh0500;
      repeat (30) @(posedge clk);
      req <= 1'b1;
      repeat (10) @(posedge clk);
      expect_out(7'b0000000);
      target <= 16'sh0300;
      wait_on(5, 100);
      expect_out(7'b1100001);
      // Slowing above the ramp limit opens torque off only
      bus(1'b1, ssm_pkg::ADDR_RAMP, 32'h00000200);
      target <= 16'sh0100;
      wait_on(3, 100);
      expect_out(7'b0101000);
      wait_on(1, 100);
      req <= 1'b0;
      pulse_ack();
      scale(1'b1, 1'b1, 16'h4E20);
      target <= 16'sh0900;
      repeat (40) @(posedge clk);
      req <= 1'b1;
      repeat (10) @(posedge clk);
      expect_out(7'b0000000);
      req <= 1'b0;
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      expect_out(7'b0000000);
      rd(ssm_pkg::ADDR_CTRL, 32'h00000000);
      end_sim();
   end
endmodule : testbench
